// *** rtl/backlight_pkg.sv ***
// constants for the backlight ramp and pwm divider block
// assumes a 200 MHz system clock and a 16 MHz nominal pwm source
package backlight_pkg;

  // command codes seen with the command/data select low
  localparam logic [7:0] CMD_RAMP_SETTING = 8'hBC;
  localparam logic [7:0] CMD_PWM_DIVIDER = 8'hBE;

  // ramp setting parameter byte layout
  localparam int RAMP_THR_MSB = 7;
  localparam int RAMP_THR_LSB = 4;
  localparam int RAMP_CODE_MSB = 2;
  localparam int RAMP_CODE_LSB = 0;

  // reset values, kept through software reset
  localparam logic [3:0] RAMP_THR_RESET = 4'h4;
  localparam logic [2:0] RAMP_CODE_RESET = 3'h4;
  localparam logic [7:0] PWM_DIV_RESET = 8'h0F;

  // widths
  localparam int BRIGHT_W = 8;
  localparam int FRAME_W = 7;
  localparam int PROD_W = 15;

  // timing: 16 MHz source made from the system clock by phase accumulation
  localparam int SYS_CLK_HZ = 200_000_000;
  localparam int SRC_CLK_HZ = 16_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;
  localparam logic [7:0] PHASE_MOD = 8'(SYS_CLK_HZ / HZ_PER_MHZ);
  localparam logic [7:0] PHASE_INC = 8'(SRC_CLK_HZ / HZ_PER_MHZ);
  localparam logic [7:0] PWM_LAST_STEP = 8'hFE;

  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b00,
    RAMP_RUN = 2'b01
  } ramp_state_t;

endpackage

// *** rtl/ramp_link_if.sv ***
// settings and brightness hand-off between the control top and the ramp unit
// assumes both ends share one clock
`timescale 1ns/1ps
interface ramp_link_if;
  logic [2:0] time_code;
  logic [3:0] threshold;
  logic [7:0] target;
  logic target_valid;
  logic frame_tick;
  logic [7:0] level;
  logic busy;

  modport ctrl (
    output time_code, threshold, target, target_valid, frame_tick,
    input level, busy
  );
  modport unit (
    input time_code, threshold, target, target_valid, frame_tick,
    output level, busy
  );
endinterface

// *** rtl/ramp_step_unit.sv ***
// brightness ramp engine: moves the level to a new target over a frame count
// assumes target_valid and frame_tick are one-cycle pulses on the same clock
`timescale 1ns/1ps
module ramp_step_unit (
  input wire logic clk_i,
  input wire logic reset_i,
  ramp_link_if.unit link
);

  backlight_pkg::ramp_state_t state_q;
  logic [7:0] level_q;
  logic [7:0] start_q;
  logic [7:0] target_q;
  logic [7:0] diff_q;
  logic up_q;
  logic [2:0] shift_q;
  logic [6:0] k_q;
  logic [7:0] diff_now;
  logic [6:0] k_next;
  logic [6:0] frames;
  logic [14:0] prod;
  logic [7:0] step;

  // frame count is a power of two, so the shift is its log
  function automatic logic [2:0] frames_log2(input logic [2:0] code);
    frames_log2 = (code <= 3'h1) ? 3'h0 : 3'(code - 3'h1);
  endfunction

  // distance from the present level to the requested one
  always_comb
  begin
    diff_now = (link.target > level_q) ? 8'(link.target - level_q) : 8'(level_q - link.target);
    k_next = 7'(k_q + 7'h01);
    frames = 7'(7'h01 << shift_q);
    prod = 15'(diff_q) * 15'(k_next);
    step = 8'(prod >> shift_q);
  end

  // ramp state and level; a new target mid-ramp restarts from the present level
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_q <= backlight_pkg::RAMP_IDLE;
      level_q <= 8'h00;
      start_q <= 8'h00;
      target_q <= 8'h00;
      diff_q <= 8'h00;
      up_q <= 1'b0;
      shift_q <= 3'h0;
      k_q <= 7'h00;
    end
    else if (link.target_valid)
    begin
      if (diff_now >= {4'h0, link.threshold})
      begin
        state_q <= backlight_pkg::RAMP_RUN;
        start_q <= level_q;
        target_q <= link.target;
        diff_q <= diff_now;
        up_q <= (link.target > level_q);
        shift_q <= frames_log2(link.time_code);
        k_q <= 7'h00;
      end
    end
    else
    begin
      case (state_q)
        backlight_pkg::RAMP_IDLE:
        begin
          k_q <= 7'h00;
        end
        backlight_pkg::RAMP_RUN:
        begin
          if (link.frame_tick)
          begin
            k_q <= k_next;
            if (k_next == frames)
            begin
              level_q <= target_q;
              state_q <= backlight_pkg::RAMP_IDLE;
            end
            else
            begin
              level_q <= up_q ? 8'(start_q + step) : 8'(start_q - step);
            end
          end
        end
        default:
        begin
          state_q <= backlight_pkg::RAMP_IDLE;
        end
      endcase
    end
  end

  assign link.level = level_q;
  assign link.busy = (state_q == backlight_pkg::RAMP_RUN);

endmodule

// *** rtl/backlight_dimming_pwm_control.sv ***
// backlight ramp setting and pwm divider commands with the pwm output generator
// assumes a host write port (command/data select, write and read strobes, data)
// from outside the clock domain, and brightness/frame pulses from on-chip logic
//
// Behaviour
// - command Backlight_ramp_setting then one byte: threshold bits 7:4, ramp code bits 2:0
// - ramp lasts 1,1,2,4,8,16,32,64 frames for codes 0 to 7
// - changes smaller than the threshold are ignored, brightness stays put
// - ramp fields reset to 0100 by hardware reset, kept on software reset
// - both commands accepted in every display, idle and sleep state
// - command Backlight_pwm_divider then one byte stored whole as the pwm divider
// - pwm frequency is 16 MHz over (divider plus one) times 255
// - pwm frequency may deviate by ten percent from nominal
// - pwm divider resets to 0Fh on hardware reset, kept on software reset
`timescale 1ns/1ps
module backlight_dimming_pwm_control (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic soft_reset_i,
  input wire logic cmd_data_select_i,
  input wire logic write_strobe_n_i,
  input wire logic read_strobe_n_i,
  input wire logic [7:0] host_data_i,
  input wire logic [7:0] target_brightness_i,
  input wire logic target_valid_i,
  input wire logic frame_start_i,
  output logic backlight_pulse_out_o,
  output logic [7:0] brightness_o,
  output logic ramp_busy_o,
  output logic [2:0] ramp_time_code_o,
  output logic [3:0] ramp_change_threshold_o,
  output logic [7:0] pwm_divider_o
);

  // host pins: first stage, second stage, and an edge-history copy of the strobe
  logic [10:0] pin_meta_q;
  logic [10:0] pin_sync_q;
  logic wr_hist_q;
  logic write_take;
  logic sel_s;
  logic rd_n_s;
  logic [7:0] data_s;

  // command decode state
  logic [7:0] cmd_q;
  logic param_open_q;

  // settings
  logic [2:0] ramp_code_q;
  logic [3:0] ramp_thr_q;
  logic [7:0] pwm_div_q;

  // pwm timebase
  logic [7:0] phase_q;
  logic src_tick_q;
  logic [7:0] prescale_q;
  logic [7:0] pwm_step_q;
  logic [7:0] duty_q;

  ramp_link_if link ();

  // two-stage synchroniser on every host pin; only stage two is read by logic
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pin_meta_q <= 11'h603;
      pin_sync_q <= 11'h603;
    end
    else
    begin
      pin_meta_q <= {write_strobe_n_i, read_strobe_n_i, cmd_data_select_i, host_data_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  // strobe history for edge detection, fed from the second stage only
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wr_hist_q <= 1'b1;
    end
    else
    begin
      wr_hist_q <= pin_sync_q[10];
    end
  end

  // a write is taken on the rising edge of the write strobe while read is idle
  always_comb
  begin
    rd_n_s = pin_sync_q[9];
    sel_s = pin_sync_q[8];
    data_s = pin_sync_q[7:0];
    write_take = pin_sync_q[10] && !wr_hist_q && rd_n_s;
  end

  // command byte opens a parameter slot; only the first parameter counts.
  // no sleep or display-mode gating here on purpose, settings stay writable
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cmd_q <= 8'h00;
      param_open_q <= 1'b0;
    end
    else if (soft_reset_i)
    begin
      cmd_q <= 8'h00;
      param_open_q <= 1'b0;
    end
    else if (write_take)
    begin
      if (!sel_s)
      begin
        cmd_q <= data_s;
        param_open_q <= 1'b1;
      end
      else
      begin
        param_open_q <= 1'b0;
      end
    end
  end

  // ramp setting fields; software reset leaves them alone
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ramp_code_q <= backlight_pkg::RAMP_CODE_RESET;
      ramp_thr_q <= backlight_pkg::RAMP_THR_RESET;
    end
    else if (write_take && sel_s && param_open_q && (cmd_q == backlight_pkg::CMD_RAMP_SETTING))
    begin
      // bit 3 is a fixed zero and is dropped
      ramp_thr_q <= data_s[backlight_pkg::RAMP_THR_MSB:backlight_pkg::RAMP_THR_LSB];
      ramp_code_q <= data_s[backlight_pkg::RAMP_CODE_MSB:backlight_pkg::RAMP_CODE_LSB];
    end
  end

  // pwm divider; software reset leaves it alone
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pwm_div_q <= backlight_pkg::PWM_DIV_RESET;
    end
    else if (write_take && sel_s && param_open_q && (cmd_q == backlight_pkg::CMD_PWM_DIVIDER))
    begin
      pwm_div_q <= data_s;
    end
  end

  // hand settings and brightness requests to the ramp unit
  assign link.time_code = ramp_code_q;
  assign link.threshold = ramp_thr_q;
  assign link.target = target_brightness_i;
  assign link.target_valid = target_valid_i;
  assign link.frame_tick = frame_start_i;

  ramp_step_unit ramp_unit (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .link(link)
  );

  // 16 MHz average tick from 200 MHz: add 16 per clock modulo 200.
  // jitter is one system clock, far inside the allowed frequency tolerance
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      phase_q <= 8'h00;
      src_tick_q <= 1'b0;
    end
    else if (phase_q >= 8'(backlight_pkg::PHASE_MOD - backlight_pkg::PHASE_INC))
    begin
      phase_q <= 8'(phase_q + backlight_pkg::PHASE_INC - backlight_pkg::PHASE_MOD);
      src_tick_q <= 1'b1;
    end
    else
    begin
      phase_q <= 8'(phase_q + backlight_pkg::PHASE_INC);
      src_tick_q <= 1'b0;
    end
  end

  // divide the source by divider plus one; a new divider applies at the next source tick
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      prescale_q <= 8'h00;
    end
    else if (src_tick_q)
    begin
      if (prescale_q >= pwm_div_q)
      begin
        prescale_q <= 8'h00;
      end
      else
      begin
        prescale_q <= 8'(prescale_q + 8'h01);
      end
    end
  end

  // 255 steps per pwm period; duty sampled at period start to avoid glitches
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pwm_step_q <= 8'h00;
      duty_q <= 8'h00;
    end
    else if (src_tick_q && (prescale_q >= pwm_div_q))
    begin
      if (pwm_step_q >= backlight_pkg::PWM_LAST_STEP)
      begin
        pwm_step_q <= 8'h00;
        duty_q <= link.level;
      end
      else
      begin
        pwm_step_q <= 8'(pwm_step_q + 8'h01);
      end
    end
  end

  // output stage: every top output is a flop
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      backlight_pulse_out_o <= 1'b0;
      brightness_o <= 8'h00;
      ramp_busy_o <= 1'b0;
      ramp_time_code_o <= backlight_pkg::RAMP_CODE_RESET;
      ramp_change_threshold_o <= backlight_pkg::RAMP_THR_RESET;
      pwm_divider_o <= backlight_pkg::PWM_DIV_RESET;
    end
    else
    begin
      backlight_pulse_out_o <= (pwm_step_q < duty_q); // full scale 255 stays high
      brightness_o <= link.level;
      ramp_busy_o <= link.busy;
      ramp_time_code_o <= ramp_code_q;
      ramp_change_threshold_o <= ramp_thr_q;
      pwm_divider_o <= pwm_div_q;
    end
  end

endmodule

// *** testbench/host_writer.sv ***
// host model: writes command and parameter bytes on the strobe pins
// assumes the device synchronises the pins to clk_i
`timescale 1ns/1ps
module host_writer (
  input wire logic clk_i,
  output logic sel_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic [7:0] data_o
);
  initial
  begin
    sel_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    data_o = 8'h00;
  end
  // strobe low 4 clocks, byte held 4 clocks past its rising edge
  task automatic put(input logic sel, input logic [7:0] d);
    @(posedge clk_i) #1;
    sel_o = sel;
    data_o = d;
    wr_n_o = 1'b0;
    repeat (4) @(posedge clk_i);
    #1 wr_n_o = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 data_o = ~d; // hold over: bus no longer valid
  endtask
endmodule

// *** testbench/backlight_dimming_pwm_control_sva.sv ***
// port assertions for the backlight ramp and pwm divider block
// assumes one clock domain; bound onto the top module below
`timescale 1ns/1ps
module backlight_dimming_pwm_control_sva (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cmd_data_select_i,
  input wire logic read_strobe_n_i,
  input wire logic [7:0] target_brightness_i,
  input wire logic target_valid_i,
  input wire logic frame_start_i,
  input wire logic [7:0] brightness_o,
  input wire logic ramp_busy_o,
  input wire logic [2:0] ramp_time_code_o,
  input wire logic [3:0] ramp_change_threshold_o,
  input wire logic [7:0] pwm_divider_o
);
  logic [7:0] gap;
  // distance to the requested level, either direction
  assign gap = (brightness_o > target_brightness_i) ? brightness_o - target_brightness_i
    : target_brightness_i - brightness_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_reset_defaults:
    assert property ($fell(reset_i) |-> pwm_divider_o == 8'h0F && ramp_time_code_o == 3'h4
      && ramp_change_threshold_o == 4'h4) else $error("settings not at defaults after reset");
  chk_set_on_param:
    assert property ($changed({ramp_time_code_o, ramp_change_threshold_o, pwm_divider_o})
      |-> $past(cmd_data_select_i, 2) && $past(read_strobe_n_i, 2)) else $error("setting changed without parameter");
  chk_busy_from_target:
    assert property ($rose(ramp_busy_o) |-> $past(target_valid_i, 2)) else $error("ramp started without target");
  chk_busy_end_frame:
    assert property ($fell(ramp_busy_o) |-> $past(frame_start_i, 2)) else $error("ramp ended off a frame");
  chk_level_on_frame:
    assert property ($changed(brightness_o) |-> $past(frame_start_i, 2)) else $error("level moved off a frame");
  chk_level_in_ramp:
    assert property ($changed(brightness_o) |-> $past(ramp_busy_o)) else $error("level moved while idle");
  chk_small_ignored:
    assert property (target_valid_i && !ramp_busy_o && !$past(target_valid_i) && gap < 8'(ramp_change_threshold_o)
      |-> ##2 !ramp_busy_o) else $error("small change started a ramp");
  chk_one_frame_ramp:
    assert property (ramp_busy_o && ramp_time_code_o <= 3'h1 && frame_start_i && !target_valid_i
      ##1 !target_valid_i |-> ##1 !ramp_busy_o) else $error("short code ramp overran");
endmodule

bind backlight_dimming_pwm_control backlight_dimming_pwm_control_sva u_sva (.clk_i(clk_i), .reset_i(reset_i),
  .cmd_data_select_i(cmd_data_select_i), .read_strobe_n_i(read_strobe_n_i),
  .target_brightness_i(target_brightness_i), .target_valid_i(target_valid_i), .frame_start_i(frame_start_i),
  .brightness_o(brightness_o), .ramp_busy_o(ramp_busy_o), .ramp_time_code_o(ramp_time_code_o),
  .ramp_change_threshold_o(ramp_change_threshold_o), .pwm_divider_o(pwm_divider_o));

// *** testbench/test_backlight_dimming_pwm_control.sv ***
// self-checking bench for the backlight ramp and pwm divider block
// assumes the host model and the bound checker are compiled first
`timescale 1ns/1ps
module test_backlight_dimming_pwm_control;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic soft_reset_i = 1'b0;
  logic [7:0] tgt = 8'h00;
  logic tvalid = 1'b0;
  logic frame = 1'b0;
  logic sel, wr_n, rd_n, pulse, busy;
  logic [7:0] hdata, level, div;
  logic [2:0] code;
  logic [3:0] thr;
  int errors = 0;
  int checks = 0;
  int n, m;
  initial
    forever #2.5 clk_i = ~clk_i;
  host_writer u_host (.clk_i(clk_i), .sel_o(sel), .wr_n_o(wr_n), .rd_n_o(rd_n), .data_o(hdata));
  backlight_dimming_pwm_control u_dut (.clk_i(clk_i), .reset_i(reset_i), .soft_reset_i(soft_reset_i),
    .cmd_data_select_i(sel), .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n), .host_data_i(hdata),
    .target_brightness_i(tgt), .target_valid_i(tvalid), .frame_start_i(frame),
    .backlight_pulse_out_o(pulse), .brightness_o(level), .ramp_busy_o(busy), .ramp_time_code_o(code),
    .ramp_change_threshold_o(thr), .pwm_divider_o(div));
  task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // hardware reset, then the power-on settings
  task automatic hw_reset();
    #1 reset_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 reset_i = 1'b0;
    @(posedge clk_i);
    compare({code, thr, div}, {3'h4, 4'h4, 8'h0F});
  endtask
  task automatic setting(input logic [7:0] cmd, input logic [7:0] prm);
    u_host.put(1'b0, cmd);
    u_host.put(1'b1, prm);
    repeat (3) @(posedge clk_i);
  endtask
  // request a level, then step the given number of frames
  task automatic ramp(input logic [7:0] t, input int frames);
    int s;
    s = level;
    @(posedge clk_i) #1;
    tgt = t;
    tvalid = 1'b1;
    @(posedge clk_i) #1;
    tvalid = 1'b0;
    repeat (3) @(posedge clk_i);
    for (int k = 1; k <= frames; k++)
    begin
      @(posedge clk_i) #1 frame = 1'b1;
      @(posedge clk_i) #1 frame = 1'b0;
      repeat (3) @(posedge clk_i);
      compare(level, s + (int'(t) - s) * k / frames);
    end
    compare({busy, level}, frames ? t : 8'(s));
  endtask
  // clocks counted up to the next rising output edge, bounded
  task automatic edge_up(inout int c);
    while (pulse !== 1'b0 && c < 90000)
    begin
      @(posedge clk_i) #1;
      c++;
    end
    while (pulse !== 1'b1 && c < 90000)
    begin
      @(posedge clk_i) #1;
      c++;
    end
  endtask
  initial
  begin
    hw_reset();
    setting(8'hBC, 8'h5B); // bit 3 set, dropped
    setting(8'hBE, 8'hA7);
    compare({code, thr, div}, {3'h3, 4'h5, 8'hA7});
    // stray parameter, unknown command, command cut by soft reset
    u_host.put(1'b1, 8'h11);
    setting(8'hBD, 8'h22);
    u_host.put(1'b0, 8'hBE);
    @(posedge clk_i) #1 soft_reset_i = 1'b1;
    @(posedge clk_i) #1 soft_reset_i = 1'b0;
    u_host.put(1'b1, 8'h33);
    // writes while the read strobe is low must be refused
    #1 u_host.rd_n_o = 1'b0;
    setting(8'hBE, 8'h55);
    #1 u_host.rd_n_o = 1'b1;
    repeat (3) @(posedge clk_i);
    compare({code, thr, div}, {3'h3, 4'h5, 8'hA7});
    hw_reset();
    for (int c = 0; c < 8; c++)
    begin
      setting(8'hBC, {5'h08, 3'(c)});
      ramp(c[0] ? 8'h10 : 8'hC8, (c < 2) ? 1 : 1 << (c - 1));
    end
    setting(8'hBC, 8'h50);
    ramp(8'h14, 0);
    ramp(8'h15, 1);
    ramp(8'h80, 1);
    for (int d = 0; d < 2; d++)
    begin
      setting(8'hBE, 8'(d));
      n = 0;
      edge_up(n);
      edge_up(n);
      m = n;
      edge_up(n);
      compare(20 * (n - m) >= (d + 1) * 57375 && 20 * (n - m) <= (d + 1) * 70125, 1'b1);
    end
    tally_and_finish();
  end
  // hang guard well past the longest expected run
  initial
  begin
    repeat (60000) @(posedge clk_i);
    errors++;
    tally_and_finish();
  end
endmodule
